// [core/ebc_defs.svh]
// offsets, field positions, reset values and timing counts of the external bus controller
`ifndef EBC_DEFS_SVH
`define EBC_DEFS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define EBC_OFF_SYSCFG    12'h000
`define EBC_OFF_DEFCFG    12'h004
`define EBC_OFF_WCFG0     12'h008
`define EBC_OFF_WRNG0     12'h018
`define EBC_OFF_STATUS    12'h028

// ****************************************************************
// field positions
// ****************************************************************
`define EBC_CFG_BUS_TYPE_FIELD_LO   0
`define EBC_CFG_ACT_BIT   2
`define EBC_CFG_DLY_LO    4
`define EBC_SYS_SPLIT_BIT 0
`define EBC_SYS_BHDIS_BIT 1
`define EBC_SYS_SEG_LO    2

// ****************************************************************
// reset values
// ****************************************************************
`define EBC_DEFCFG_RST    32'h0000_00f6
`define EBC_SYSCFG_RST    32'h0000_000c

// ****************************************************************
// timing
// ****************************************************************
`define EBC_CLK_NS        20
`define EBC_MUX_SWITCH_NS 20
`define EBC_MUX_SWITCH_CYC ((`EBC_MUX_SWITCH_NS + `EBC_CLK_NS - 1) / `EBC_CLK_NS)

`endif

// [core/ebc_ext_bus_ctrl.sv]
// external bus controller: window decode, bus cycle sequencing and ahb-lite registers
//
// Summary of operation
// R1: demux modes keep address on addr port; data on full or low port byte.
// R2: segment address lines driven steadily when the reset-time selection enables them.
// R3: demux cycle puts address first, command strobe after programmable delay.
// R4: read data latched, then strobe released; device then floats the bus.
// R5: write strobe released, data held until next cycle; next address then driven.
// R6: each access decoded: internal, one of four windows, or default.
// R7: external addresses outside every window use the default configuration.
// R8: any demux window keeps intra-segment address on addr port every cycle.
// R9: with no demux window the addr port is released for general use.
// R10: software must not reprogram a window currently supplying instructions.
// R11: mux cycle after demux cycle delays port address by one clock.
// R12: 8-bit bus uses low port byte only; 16-bit uses whole port.
// R13: word on 8-bit bus runs two byte cycles, low byte first.
// R14: 16-bit byte access: high byte strobe for upper, bit zero for lower.
// R15: split bit set: write pin writes low byte, high byte pin writes high.
// R16: byte write on 16-bit bus drives the byte on both halves.
// R17: byte read on 16-bit bus fetches word and keeps addressed byte.
// R18: for read-sensitive devices select bytes with high byte strobe and bit zero.
// R19: bus type field: 00 8 demux, 01 8 mux, 10 16 demux, 11 16 mux.
// R20: mux cycle raises latch strobe with address; latch captures on falling edge. After a demux cycle the strobe rises one clock before the address.
// R21: high byte pin active while its disable bit is zero, else general use.
//
// The AHB-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "ebc_defs.svh"

module ebc_ext_bus_ctrl (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hsel,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire ebc_pkg::ebc_req_t req,
  output ebc_pkg::ebc_rsp_t      rsp,
  output logic                   req_internal,
  input  wire logic [15:0]       mux_addr_data_in,
  output ebc_pkg::ebc_pins_t     pins
);
  import ebc_pkg::*;

  // ****************************************************************
  // registers over ahb-lite
  // ****************************************************************
  logic [31:0] sys_cfg_q;
  logic [31:0] win_cfg_q [0:4];
  logic [31:0] win_rng_q [0:4];
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] rdata_d;
  logic        busy_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else if (hready) begin
      wr_pend_q <= hsel && htrans[1] && hwrite;
      wr_addr_q <= haddr[11:0];
    end
  end

  // R10 is software's duty; writes take effect at the end of the data phase
  always_ff @(posedge clk) begin
    if (reset) begin
      sys_cfg_q <= `EBC_SYSCFG_RST;
      for (int i = 0; i < 5; i++) begin
        win_cfg_q[i] <= (i == 0) ? `EBC_DEFCFG_RST : 32'h0000_0000;
        win_rng_q[i] <= 32'h0000_0000;
      end
    end else if (wr_pend_q) begin
      if (wr_addr_q == `EBC_OFF_SYSCFG)
        sys_cfg_q <= hwdata;
      for (int i = 0; i < 5; i++) begin
        if (wr_addr_q == 12'(`EBC_OFF_DEFCFG + 4 * i) && i == 0)
          win_cfg_q[0] <= hwdata;
        if (i > 0 && wr_addr_q == 12'(`EBC_OFF_WCFG0 + 4 * (i - 1)))
          win_cfg_q[i] <= hwdata;
        if (i > 0 && wr_addr_q == 12'(`EBC_OFF_WRNG0 + 4 * (i - 1)))
          win_rng_q[i] <= hwdata;
      end
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (haddr[11:0] == `EBC_OFF_SYSCFG)
      rdata_d = sys_cfg_q;
    if (haddr[11:0] == `EBC_OFF_DEFCFG)
      rdata_d = win_cfg_q[0];
    if (haddr[11:0] == `EBC_OFF_STATUS)
      rdata_d = {31'h0000_0000, busy_q};
    for (int i = 1; i < 5; i++) begin
      if (haddr[11:0] == 12'(`EBC_OFF_WCFG0 + 4 * (i - 1)))
        rdata_d = win_cfg_q[i];
      if (haddr[11:0] == 12'(`EBC_OFF_WRNG0 + 4 * (i - 1)))
        rdata_d = win_rng_q[i];
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
      hrdata <= rdata_d;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ****************************************************************
  // window decode
  // ****************************************************************
  // range word: [23:16] base segment, [7:0] segment count minus one
  function automatic logic in_window(input logic [31:0] rng, input logic [23:0] a);
    in_window = (a[23:16] >= rng[23:16]) && ({1'b0, a[23:16]} <= ({1'b0, rng[23:16]} + {1'b0, rng[7:0]}));
  endfunction

  logic [2:0] win_sel;
  logic       any_demux;
  always_comb begin
    win_sel      = 3'h0; // R7
    req_internal = (req.addr[23:16] == 8'h00); // R6
    for (int i = 4; i >= 1; i--) begin
      if (win_cfg_q[i][`EBC_CFG_ACT_BIT] && in_window(win_rng_q[i], req.addr))
        win_sel = 3'(i); // R6
    end
    any_demux = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (win_cfg_q[i][`EBC_CFG_ACT_BIT] && !win_cfg_q[i][`EBC_CFG_BUS_TYPE_FIELD_LO])
        any_demux = 1'b1; // R8
    end
  end

  // ****************************************************************
  // bus cycle sequencer
  // ****************************************************************
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_SWITCH, S_DELAY, S_CMD, S_DONE} ebc_state_t;
  ebc_state_t  state_q;
  ebc_bus_type_field_t   bus_type_field_q;
  logic        prev_demux_q;
  logic        second_q;
  logic        write_q;
  logic        word_q;
  logic [23:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic [15:0] drive_q;
  logic        drive_en_q;
  logic [3:0]  cnt_q;
  logic        rd_q;
  logic        wr_q;
  logic        ale_q;
  logic        done_q;

  wire cfg_b16   = bus_type_field_q[1]; // R19
  wire cfg_mux   = bus_type_field_q[0]; // R19
  wire split_cfg = sys_cfg_q[`EBC_SYS_SPLIT_BIT];

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q      <= S_IDLE;
      bus_type_field_q       <= EBC_B16_DEMUX;
      prev_demux_q <= 1'b0;
      second_q     <= 1'b0;
      write_q      <= 1'b0;
      word_q       <= 1'b0;
      addr_q       <= 24'h00_0000;
      wdata_q      <= 16'h0000;
      rdata_q      <= 16'h0000;
      cnt_q        <= 4'h0;
      rd_q         <= 1'b0;
      wr_q         <= 1'b0;
      ale_q        <= 1'b0;
      done_q       <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (req.valid && !req_internal && !done_q) begin
            bus_type_field_q   <= ebc_bus_type_field_t'(win_cfg_q[win_sel][1:0]); // R6
            write_q  <= req.write;
            word_q   <= req.word;
            addr_q   <= req.addr;
            wdata_q  <= req.wdata;
            second_q <= 1'b0;
            state_q  <= S_ADDR;
          end
        end
        S_ADDR: begin
          cnt_q <= win_cfg_q[win_sel][`EBC_CFG_DLY_LO +: 4];
          if (cfg_mux) begin
            ale_q   <= 1'b1; // R20
            state_q <= prev_demux_q ? S_SWITCH : S_DELAY; // R11
          end else begin
            state_q <= S_DELAY; // R3
          end
        end
        S_SWITCH: begin
          state_q <= S_DELAY; // R11
        end
        S_DELAY: begin
          ale_q <= 1'b0; // R20
          if (cnt_q == 4'h0) begin
            rd_q    <= !write_q; // R3
            wr_q    <= write_q; // R3
            state_q <= S_CMD;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        S_CMD: begin
          rd_q         <= 1'b0; // R4
          wr_q         <= 1'b0; // R5
          prev_demux_q <= !cfg_mux;
          if (!write_q) begin
            if (!cfg_b16 && second_q)
              rdata_q[15:8] <= mux_addr_data_in[7:0]; // R13
            else if (!cfg_b16)
              rdata_q[7:0] <= mux_addr_data_in[7:0]; // R12
            else if (!word_q && addr_q[0])
              rdata_q <= {8'h00, mux_addr_data_in[15:8]}; // R17
            else if (!word_q)
              rdata_q <= {8'h00, mux_addr_data_in[7:0]}; // R17
            else
              rdata_q <= mux_addr_data_in;
          end
          if (!cfg_b16 && word_q && !second_q) begin
            second_q <= 1'b1; // R13
            addr_q   <= addr_q | 24'h00_0001;
            state_q  <= S_ADDR;
          end else begin
            state_q <= S_DONE;
          end
        end
        S_DONE: begin
          done_q  <= 1'b1;
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // port drive: address phase on mux cycles, write data until next cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      drive_q    <= 16'h0000;
      drive_en_q <= 1'b0;
    end else if (state_q == S_ADDR && cfg_mux && !prev_demux_q) begin
      drive_q    <= addr_q[15:0]; // R20
      drive_en_q <= 1'b1;
    end else if (state_q == S_SWITCH) begin
      drive_q    <= addr_q[15:0]; // R11
      drive_en_q <= 1'b1;
    end else if (state_q == S_DELAY && write_q) begin
      if (!cfg_b16 && second_q)
        drive_q <= {8'h00, wdata_q[15:8]}; // R13
      else if (!cfg_b16 || word_q)
        drive_q <= cfg_b16 ? wdata_q : {8'h00, wdata_q[7:0]}; // R12
      else
        drive_q <= addr_q[0] ? {wdata_q[7:0], wdata_q[7:0]} : {wdata_q[7:0], wdata_q[7:0]}; // R16
      drive_en_q <= 1'b1; // R5
    end else if (state_q == S_DELAY || (state_q == S_ADDR && !cfg_mux)) begin
      drive_en_q <= write_q && (state_q == S_DELAY); // R4
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      busy_q <= 1'b0;
    else
      busy_q <= (state_q != S_IDLE);
  end

  // ****************************************************************
  // pins
  // ****************************************************************
  logic hb_sel;
  always_comb begin
    hb_sel = cfg_b16 && (word_q || addr_q[0]); // R14
    pins.addr_port          = addr_q[15:0]; // R1
    pins.addr_port_oe       = any_demux; // R9
    pins.segment_addr_port  = addr_q[23:16]; // R2
    pins.segment_addr_oe    = sys_cfg_q[`EBC_SYS_SEG_LO +: 8]; // R2
    pins.mux_addr_data_port = drive_q;
    pins.mux_addr_data_oe   = cfg_b16 ? {16{drive_en_q}} : {8'h00, {8{drive_en_q}}}; // R12
    pins.addr_latch_strobe  = ale_q;
    pins.read_strobe_n      = !rd_q;
    if (split_cfg) begin
      pins.write_low_strobe_n = !(wr_q && (!cfg_b16 || word_q || !addr_q[0])); // R15
      pins.high_byte_strobe_n = !(wr_q && hb_sel); // R15
    end else begin
      pins.write_low_strobe_n = !wr_q;
      pins.high_byte_strobe_n = !((rd_q || wr_q) && hb_sel); // R14
    end
    pins.high_byte_oe = !sys_cfg_q[`EBC_SYS_BHDIS_BIT]; // R21
    rsp.done          = done_q;
    rsp.rdata         = rdata_q;
  end
  // R18 is for the system designer: with split clear, byte reads here still use strobe and bit zero
endmodule

// [core/ebc_pkg.sv]
// types shared by the external bus controller
package ebc_pkg;

  typedef enum logic [1:0] {
    EBC_B8_DEMUX  = 2'h0,
    EBC_B8_MUX    = 2'h1,
    EBC_B16_DEMUX = 2'h2,
    EBC_B16_MUX   = 2'h3
  } ebc_bus_type_field_t;

  // cpu side request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } ebc_req_t;

  // cpu side answer
  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
  } ebc_rsp_t;

  // external pins, outputs
  typedef struct packed {
    logic [15:0] addr_port;
    logic        addr_port_oe;
    logic [7:0]  segment_addr_port;
    logic [7:0]  segment_addr_oe;
    logic [15:0] mux_addr_data_port;
    logic [15:0] mux_addr_data_oe;
    logic        addr_latch_strobe;
    logic        read_strobe_n;
    logic        write_low_strobe_n;
    logic        high_byte_strobe_n;
    logic        high_byte_oe;
  } ebc_pins_t;

endpackage

// [sim/ebc_ext_bus_ctrl_props.sv]
// concurrent checks on the external bus controller ports
`timescale 1ns/1ns
module ebc_ext_bus_ctrl_props
  import ebc_pkg::*;
(
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire ebc_pkg::ebc_req_t  req,
  input wire ebc_pkg::ebc_rsp_t  rsp,
  input wire logic               req_internal,
  input wire ebc_pkg::ebc_pins_t pins
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence cmd_off_s;
    pins.read_strobe_n && pins.write_low_strobe_n;
  endsequence
  sequence cmd_on_s;
    $fell(pins.read_strobe_n) || $fell(pins.write_low_strobe_n);
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  addr_first_a: assert property (cmd_on_s |-> $stable(pins.addr_port))
    else $error("address moved as command started");
  read_float_a: assert property (!pins.read_strobe_n |-> pins.mux_addr_data_oe == 16'h0)
    else $error("port driven during read command");
  wr_keep_a: assert property ($rose(pins.write_low_strobe_n) |=> $stable(pins.mux_addr_data_port))
    else $error("write data dropped after command");
  ale_alone_a: assert property (pins.addr_latch_strobe |-> cmd_off_s)
    else $error("command active with latch strobe");
  done_idle_a: assert property (rsp.done |-> cmd_off_s ##1 !rsp.done)
    else $error("done not a single pulse after command");
  done_bound_a: assert property ($rose(req.valid) && !req_internal |-> ##[4:60] rsp.done)
    else $error("external access never completed");
  int_quiet_a: assert property (req.valid && req_internal |-> (!rsp.done) and cmd_off_s)
    else $error("internal access reached the bus");
  seg_lines_a: assert property (!pins.read_strobe_n |-> (pins.segment_addr_port & pins.segment_addr_oe) == (req.addr[23:16] & pins.segment_addr_oe))
    else $error("segment lines wrong during read");
endmodule
bind ebc_ext_bus_ctrl ebc_ext_bus_ctrl_props chk_u (
  .clk, .reset, .hreadyout, .hresp, .req, .rsp, .req_internal, .pins);

// [sim/ebc_ext_mem.sv]
// behavioural external byte memory on the parallel bus
`timescale 1ns/1ns
module ebc_ext_mem
  import ebc_pkg::*;
(
  input  wire logic              clk,
  input  wire ebc_pkg::ebc_pins_t pins,
  input  wire logic              wide,
  input  wire logic              split,
  output logic [15:0]            dq
);
  logic [7:0]  mem [0:255];
  logic [7:0]  a;
  logic [7:0]  pa;
  logic [15:0] last_q = 16'h0;
  ebc_pins_t   p_q    = '1;
  assign a  = pins.addr_port[7:0];
  assign pa = p_q.addr_port[7:0];
  // released bus shows the inverted last value so a stale sample cannot pass
  always_comb begin
    if (!pins.read_strobe_n)
      dq = wide ? {mem[a | 8'h1], mem[a & 8'hfe]} : {~last_q[15:8], mem[a]};
    else
      dq = ~last_q;
  end
  // writes land as the strobe rises, with data sampled while it was low
  always @(posedge clk) begin
    p_q <= pins;
    // remember what the device drove while selected, so the released bus shows its inverse
    if (!pins.read_strobe_n)
      last_q <= dq;
    if (!p_q.write_low_strobe_n && pins.write_low_strobe_n) begin
      if (!wide)
        mem[pa] <= p_q.mux_addr_data_port[7:0];
      else begin
        if (split || !pa[0])
          mem[pa & 8'hfe] <= p_q.mux_addr_data_port[7:0];
        if (!split && !p_q.high_byte_strobe_n)
          mem[pa | 8'h1] <= p_q.mux_addr_data_port[15:8];
      end
    end
    if (split && wide && !p_q.high_byte_strobe_n && pins.high_byte_strobe_n)
      mem[pa | 8'h1] <= p_q.mux_addr_data_port[15:8];
  end
endmodule

// [sim/tb_ebc_ext_bus_ctrl.sv]
// self-checking bench for the external bus controller
`timescale 1ns/1ns
module tb_ebc_ext_bus_ctrl;
  import ebc_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic        hsel = 1'b0;
  logic        hreadyout, hresp, req_internal;
  logic        wide = 1'b1;
  logic        split = 1'b0;
  logic        wl_q = 1'b1;
  ebc_req_t    req = '0;
  ebc_rsp_t    rsp;
  ebc_pins_t   pins;
  logic [15:0] mem_dq, bus_in, wr_seen, q;
  logic [15:0] wa_q[$];
  int          num_errors = 0, total_checks = 0, lo_cnt = 0, hi_cnt = 0, ale_cnt = 0;
  int          n, m, l0, h0;
  always #10 clk = ~clk;
  assign bus_in = (pins.mux_addr_data_oe & pins.mux_addr_data_port)
                | (~pins.mux_addr_data_oe & mem_dq);
  ebc_ext_bus_ctrl dut_u (.clk, .reset, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hsel, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .req, .rsp, .req_internal,
    .mux_addr_data_in(bus_in), .pins);
  ebc_ext_mem mem_u (.clk, .pins, .wide, .split, .dq(mem_dq));
  // ****************
  // bus watchers
  // ****************
  always @(posedge clk) begin
    if (!pins.write_low_strobe_n || (split && !pins.high_byte_strobe_n))
      wr_seen <= pins.mux_addr_data_port & pins.mux_addr_data_oe;
    if (!pins.write_low_strobe_n && wl_q)
      wa_q.push_back(pins.addr_port);
    wl_q <= pins.write_low_strobe_n;
    lo_cnt <= lo_cnt + int'(!pins.write_low_strobe_n);
    hi_cnt <= hi_cnt + int'(!pins.high_byte_strobe_n);
    ale_cnt <= ale_cnt + int'(pins.addr_latch_strobe);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic guard(input int k);
    if (k >= 50) begin
      num_errors++;
      $display("ERROR t=%0t wait limit got=%h exp=%h", $time, k, 0);
      tally_and_finish();
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int k;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    k = 0;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    guard(k);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    k = 0;
    do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
    guard(k);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // holds the request until done, as the handshake asks
  task automatic xfer(input logic w, input logic wd, input logic [23:0] a,
                      input logic [15:0] d);
    @(posedge clk);
    req <= '{1'b1, w, wd, a, d};
    n = 0;
    do begin @(posedge clk); n++; end while (rsp.done !== 1'b1 && n < 50);
    guard(n);
    q = rsp.rdata;
    req.valid <= 1'b0;
  endtask
  task automatic t_reset();
    rd_chk(12'h004, 32'h0000_00f6);
    rd_chk(12'h000, 32'h0000_000c);
    chk(pins.segment_addr_oe, 8'h03);
    chk(pins.addr_port_oe, 1'b1);
    chk(pins.high_byte_oe, 1'b1);
    wr(12'h100, 32'hffff_ffff);
    rd_chk(12'h100, 32'h0);
  endtask
  task automatic t_wide16();
    xfer(1'b1, 1'b1, 24'h01_0010, 16'hbeef);
    m = n;
    wr(12'h004, 32'h0000_0006);
    xfer(1'b1, 1'b1, 24'h01_0010, 16'hbeef);
    chk(m - n, 15);
    xfer(1'b0, 1'b1, 24'h01_0010, 16'h0);
    chk(q, 16'hbeef);
    xfer(1'b1, 1'b0, 24'h01_0011, 16'h005a);
    chk(wr_seen, 16'h5a5a);
    xfer(1'b0, 1'b1, 24'h01_0010, 16'h0);
    chk(q, 16'h5aef);
    h0 = hi_cnt;
    xfer(1'b0, 1'b0, 24'h01_0010, 16'h0);
    chk(hi_cnt - h0, 0);
    h0 = hi_cnt;
    xfer(1'b0, 1'b0, 24'h01_0011, 16'h0);
    chk(q, 16'h005a);
    chk(hi_cnt > h0, 1'b1);
  endtask
  task automatic t_narrow();
    wr(12'h008, 32'h0000_0004);
    wr(12'h018, 32'h0002_0000);
    wide <= 1'b0;
    wa_q.delete();
    xfer(1'b1, 1'b1, 24'h02_0020, 16'h1234);
    chk(wa_q.size(), 2);
    chk(wa_q[0], 16'h0020);
    chk(wa_q[1], 16'h0021);
    chk(wr_seen, 16'h0012);
    xfer(1'b0, 1'b1, 24'h02_0020, 16'h0);
    chk(q, 16'h1234);
  endtask
  task automatic t_switch();
    wr(12'h00c, 32'h0000_0007);
    wr(12'h01c, 32'h0003_0000);
    wr(12'h010, 32'h0000_0005);
    wr(12'h020, 32'h0004_0000);
    wide <= 1'b1;
    xfer(1'b0, 1'b1, 24'h01_0010, 16'h0);
    l0 = ale_cnt;
    xfer(1'b0, 1'b1, 24'h03_0010, 16'h0);
    m = n;
    chk(ale_cnt > l0, 1'b1);
    xfer(1'b0, 1'b1, 24'h03_0010, 16'h0);
    chk(m - n, 1);
    chk(q, 16'h5aef);
    chk(pins.addr_port_oe, 1'b1);
    xfer(1'b0, 1'b1, 24'h05_0010, 16'h0);
    chk(q, 16'h5aef);
    wide <= 1'b0;
    xfer(1'b0, 1'b1, 24'h04_0020, 16'h0);
    chk(q, 16'h1234);
    wide <= 1'b1;
  endtask
  task automatic t_release();
    wr(12'h004, 32'h0000_0007);
    wr(12'h008, 32'h0000_0005);
    @(posedge clk);
    chk(pins.addr_port_oe, 1'b0);
    wr(12'h004, 32'h0000_0006);
    @(posedge clk);
    chk(pins.addr_port_oe, 1'b1);
  endtask
  task automatic t_split();
    wr(12'h000, 32'h0000_000d);
    split <= 1'b1;
    xfer(1'b1, 1'b1, 24'h01_0040, 16'h1111);
    l0 = lo_cnt;
    h0 = hi_cnt;
    xfer(1'b1, 1'b0, 24'h01_0041, 16'h00c3);
    chk(lo_cnt - l0, 0);
    chk(hi_cnt > h0, 1'b1);
    xfer(1'b0, 1'b1, 24'h01_0040, 16'h0);
    chk(q, 16'hc311);
    wr(12'h000, 32'h0000_000e);
    split <= 1'b0;
    @(posedge clk);
    chk(pins.high_byte_oe, 1'b0);
  endtask
  task automatic t_internal();
    @(posedge clk);
    req <= '{1'b1, 1'b0, 1'b1, 24'h00_0100, 16'h0};
    m = 0;
    repeat (10) begin
      @(posedge clk);
      m += int'(rsp.done === 1'b1);
    end
    chk(req_internal, 1'b1);
    chk(m, 0);
    req.valid <= 1'b0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_wide16();
    t_narrow();
    t_switch();
    t_release();
    t_split();
    t_internal();
    tally_and_finish();
  end
endmodule
